//--- tb/accel_sample_fifo_readout_assertions.sv
/*
  Port-level checks on the acceleration sample FIFO readout.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none

module accel_fifo_checker (
  input wire logic       clock_i,
  input wire logic       rstn_i,
  input wire logic       scl_i,
  input wire logic       sample_active_i,
  input wire logic       sample_sleep_i,
  input wire logic       sleep_i,
  input wire logic       trigger_i,
  input wire logic       sda_o,
  input wire logic       sda_oen_o,
  input wire logic       fifo_irq_source_o,
  input wire logic       fifo_status_read_o,
  input wire logic [2:0] axis_high_read_o
);
  default clocking dclk @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // ==========================================================================
  // Helpers
  // Only the strobe of the rate in force may load a sample.
  wire new_sample = (sample_active_i & ~sleep_i) | (sample_sleep_i & sleep_i);

  // ==========================================================================
  // Properties
  AST_OPEN_DRAIN: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  AST_TURN_SCL_LOW: assert property ($changed(sda_oen_o) |-> !$past(scl_i))
    else $error("data enable moved while clock high");
  AST_IRQ_CLEAR: assert property ((fifo_status_read_o && !new_sample && !$past(new_sample))
    ##1 !new_sample |=> !fifo_irq_source_o)
    else $error("status read left irq source set");
  AST_IRQ_KEEP: assert property ($fell(fifo_irq_source_o) |->
    fifo_status_read_o || $past(fifo_status_read_o) || $past(fifo_status_read_o, 2))
    else $error("irq source cleared without a status read");
  AST_IRQ_CAUSE: assert property ($rose(fifo_irq_source_o) |->
    $past(new_sample) || $past(trigger_i) || $past(trigger_i, 2) || $past(trigger_i, 3))
    else $error("irq source set without a cause");
  AST_STATUS_PULSE: assert property (fifo_status_read_o |=> (!fifo_status_read_o) [*8])
    else $error("status fetches too close");
  AST_HIGH_PULSE: assert property (axis_high_read_o != 3'h0 |=> (axis_high_read_o == 3'h0) [*8])
    else $error("high byte fetches too close");
  AST_HIGH_ONE_AXIS: assert property ($onehot0(axis_high_read_o))
    else $error("two axes fetched at once");
  AST_FETCH_SCL_LOW: assert property (fifo_status_read_o || axis_high_read_o != 3'h0 |-> !$past(scl_i))
    else $error("fetch not at a clock low phase");
endmodule

bind accel_sample_fifo_readout accel_fifo_checker i_chk (
  .clock_i            (clock_i),
  .rstn_i             (rstn_i),
  .scl_i              (scl_i),
  .sample_active_i    (sample_active_i),
  .sample_sleep_i     (sample_sleep_i),
  .sleep_i            (sleep_i),
  .trigger_i          (trigger_i),
  .sda_o              (sda_o),
  .sda_oen_o          (sda_oen_o),
  .fifo_irq_source_o  (fifo_irq_source_o),
  .fifo_status_read_o (fifo_status_read_o),
  .axis_high_read_o   (axis_high_read_o)
);
`default_nettype wire

//--- tb/accel_sample_fifo_readout_tb.sv
/*
  Self-checking bench for the acceleration sample FIFO and readout.
  Assumes the host model owns the bus and the checker is bound in.
*/
`timescale 1ns/10ps
`default_nettype none

module accel_sample_fifo_readout_tb;
  localparam int LIMIT = 40000;
  logic        clock_i = 1'b0;
  logic        rstn_i, sample_active_i, sample_sleep_i, sleep_i, active_i, fast_read_i, trigger_i;
  logic [11:0] x_i, y_i, z_i;
  logic [7:0]  data_status_i;
  logic        sda_o, sda_oen_o, fifo_irq_source_o, fifo_status_read_o, scl_w, host_sda;
  logic [2:0]  axis_high_read_o;
  wire         sda_w = (sda_oen_o | sda_o) & host_sda;
  int          checks = 0;
  int          bad_count = 0;
  int          cycles = 0;
  int          hi_seen = 0;
  int          st_seen = 0;

  always #50 clock_i = ~clock_i;

  // The fetch strobes stand one cycle; count them mid-cycle, where they are settled.
  always @(negedge clock_i) begin
    if (axis_high_read_o != 3'h0)
      hi_seen++;
    if (fifo_status_read_o)
      st_seen++;
  end

  accel_sample_fifo_readout i_dut (
    .clock_i            (clock_i),
    .rstn_i             (rstn_i),
    .scl_i              (scl_w),
    .sda_i              (sda_w),
    .sample_active_i    (sample_active_i),
    .sample_sleep_i     (sample_sleep_i),
    .sleep_i            (sleep_i),
    .active_i           (active_i),
    .fast_read_i        (fast_read_i),
    .trigger_i          (trigger_i),
    .x_i                (x_i),
    .y_i                (y_i),
    .z_i                (z_i),
    .data_status_i      (data_status_i),
    .sda_o              (sda_o),
    .sda_oen_o          (sda_oen_o),
    .fifo_irq_source_o  (fifo_irq_source_o),
    .fifo_status_read_o (fifo_status_read_o),
    .axis_high_read_o   (axis_high_read_o)
  );

  i2c_host_model i_host (
    .sda_i (sda_w),
    .scl_o (scl_w),
    .sda_o (host_sda)
  );

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Byte i of sample n: axis tag in the top nibble, low bytes left-justified.
  function automatic logic [7:0] sb(input logic [7:0] n, input int i);
    logic [11:0] v;
    v = {4'ha + 4'(i / 2), n};
    return (i % 2 == 1) ? {v[3:0], 4'h0} : v[11:4];
  endfunction

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_host.read_regs(a, 1);
    chk(i_host.rx[0], exp);
  endtask

  task automatic samp(input logic [7:0] n);
    i_host.read_regs(8'h01, 6);
    for (int i = 0; i < 6; i++) chk(i_host.rx[i], sb(n, i));
  endtask

  task automatic push(input logic [7:0] n);
    @(negedge clock_i);
    x_i = {4'ha, n};
    y_i = {4'hb, n};
    z_i = {4'hc, n};
    sample_active_i = ~sleep_i;
    sample_sleep_i = sleep_i;
    @(negedge clock_i);
    sample_active_i = 1'b0;
    sample_sleep_i = 1'b0;
    @(negedge clock_i);
  endtask

  // The level threshold may only change in standby, and only after a disable.
  task automatic cfg(input logic [7:0] v);
    @(negedge clock_i);
    active_i = 1'b0;
    i_host.write_reg(8'h09, 8'h00);
    i_host.write_reg(8'h09, v);
    @(negedge clock_i);
    active_i = 1'b1;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      print_verdict;
    end
  end

  // ==========================================================================
  // Tests
  initial begin
    rstn_i = 1'b0;
    {sample_active_i, sample_sleep_i, sleep_i, fast_read_i, trigger_i} = 5'h00;
    active_i = 1'b1;
    {x_i, y_i, z_i} = 36'h0;
    data_status_i = 8'h5a;
    repeat (3) @(negedge clock_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge clock_i);
    rd(8'h09, 8'h00);
    push(8'h37);
    i_host.read_regs(8'h00, 7);
    chk(i_host.rx[0], 8'h5a);
    for (int i = 0; i < 6; i++) chk(i_host.rx[i + 1], sb(8'h37, i));
    chk(8'(hi_seen), 8'h03);
    @(negedge clock_i);
    fast_read_i = 1'b1;
    i_host.read_regs(8'h00, 4);
    for (int i = 0; i < 3; i++) chk(i_host.rx[i + 1], sb(8'h37, 2 * i));
    @(negedge clock_i);
    fast_read_i = 1'b0;
    rd(8'h02, 8'h00);
    push(8'h41);
    fork
      i_host.read_regs(8'h01, 2);
      #27000 push(8'h42);
    join
    chk(i_host.rx[0], sb(8'h41, 0));
    chk(i_host.rx[1], sb(8'h41, 1));
    i_host.read_regs(8'h01, 2);
    chk(i_host.rx[0], sb(8'h42, 0));
    chk(i_host.rx[1], sb(8'h42, 1));
    $display("test direct_readout done");
    cfg(8'h44);
    for (int n = 0; n < 3; n++) push(8'(n));
    rd(8'h00, 8'h03);
    chk(8'(st_seen), 8'h01);
    chk({7'h00, fifo_irq_source_o}, 8'h00);
    push(8'h03);
    chk({7'h00, fifo_irq_source_o}, 8'h01);
    rd(8'h00, 8'h44);
    chk({7'h00, fifo_irq_source_o}, 8'h00);
    rd(8'h02, 8'h00);
    samp(8'h00);
    rd(8'h00, 8'h03);
    for (int n = 4; n < 33; n++) push(8'(n));
    rd(8'h00, 8'he0);
    push(8'h21);
    chk({7'h00, fifo_irq_source_o}, 8'h01);
    rd(8'h00, 8'he0);
    samp(8'h02);
    @(negedge clock_i);
    fast_read_i = 1'b1;
    i_host.read_regs(8'h01, 3);
    for (int i = 0; i < 3; i++) chk(i_host.rx[i], sb(8'h03, 2 * i));
    @(negedge clock_i);
    fast_read_i = 1'b0;
    $display("test circular done");
    @(negedge clock_i);
    active_i = 1'b0;
    i_host.write_reg(8'h09, 8'h00);
    rd(8'h00, 8'h5a);
    i_host.write_reg(8'h09, 8'h80);
    rd(8'h00, 8'h00);
    @(negedge clock_i);
    active_i = 1'b1;
    for (int n = 0; n < 33; n++) push(8'(n + 8'h50));
    rd(8'h00, 8'ha0);
    samp(8'h50);
    $display("test fill done");
    cfg(8'hc4);
    for (int n = 0; n < 6; n++) push(8'(n + 8'h70));
    rd(8'h00, 8'h04);
    @(negedge clock_i);
    trigger_i = 1'b1;
    @(negedge clock_i);
    trigger_i = 1'b0;
    for (int n = 0; n < 40; n++) push(8'(n + 8'h80));
    rd(8'h00, 8'he0);
    samp(8'h72);
    $display("test trigger done");
    cfg(8'h40);
    push(8'h01);
    @(negedge clock_i);
    sleep_i = 1'b1;
    rd(8'h00, 8'h00);
    push(8'h02);
    @(negedge clock_i);
    sample_active_i = 1'b1;
    @(negedge clock_i);
    sample_active_i = 1'b0;
    rd(8'h00, 8'h01);
    @(negedge clock_i);
    active_i = 1'b0;
    @(negedge clock_i);
    active_i = 1'b1;
    rd(8'h00, 8'h00);
    $display("test flush done");
    chk(i_host.nak_cnt, 8'h00);
    print_verdict;
  end
endmodule
`default_nettype wire

//--- tb/i2c_host_model.sv
/*
  Behavioural I2C bus controller standing for the host processor.
  Assumes the open-drain data line and its pull-up are resolved outside.
*/
`timescale 1ns/10ps
`default_nettype none

module i2c_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h1d
) (
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_o
);
  logic [7:0] rx [0:7];
  logic [7:0] nak_cnt;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    nak_cnt = 8'h00;
  end

  // ==========================================================================
  // Bit level
  // Clock low 500 ns: the slave needs up to 300 ns to turn the line round.
  task automatic bit_io(input logic b, output logic r);
    #100 sda_o = b;
    #400 scl_o = 1'b1;
    #150 r = sda_i;
    #150 scl_o = 1'b0;
  endtask

  task automatic start_cond;
    #100 sda_o = 1'b1;
    #400 scl_o = 1'b1;
    #400 sda_o = 1'b0;
    #400 scl_o = 1'b0;
  endtask

  task automatic stop_cond;
    #100 sda_o = 1'b0;
    #400 scl_o = 1'b1;
    #300 sda_o = 1'b1;
    #400;
  endtask

  // ==========================================================================
  // Byte level and transfers
  task automatic byte_io(input logic [7:0] tx, input logic ack_i, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r[i]);
    end
    bit_io(ack_i, ack);
  endtask

  task automatic send(input logic [7:0] v);
    logic [7:0] d;
    logic       a;
    byte_io(v, 1'b1, d, a);
    if (a) nak_cnt = nak_cnt + 8'h01;
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    start_cond;
    send({DEV_ADDR, 1'b0});
    send(a);
    send(d);
    stop_cond;
  endtask

  task automatic read_regs(input logic [7:0] a, input int n);
    logic a2;
    start_cond;
    send({DEV_ADDR, 1'b0});
    send(a);
    start_cond;
    send({DEV_ADDR, 1'b1});
    for (int i = 0; i < n; i++) begin
      byte_io(8'hff, i == n - 1, rx[i], a2);
    end
    stop_cond;
  endtask
endmodule
`default_nettype wire

//--- verilog/accel_fifo_defines.vh
/*
  Register offsets, field positions, reset values and mode codes of the
  acceleration sample FIFO and its readout port.
  Assumes it is included by its bare name from the design file that needs it.
*/
`ifndef ACCEL_FIFO_DEFINES_VH
`define ACCEL_FIFO_DEFINES_VH

// ============================================================================
// Register offsets
`define REG_FIFO_STATUS   8'h00
`define REG_X_ACCEL_HIGH  8'h01
`define REG_X_ACCEL_LOW   8'h02
`define REG_Y_ACCEL_HIGH  8'h03
`define REG_Y_ACCEL_LOW   8'h04
`define REG_Z_ACCEL_HIGH  8'h05
`define REG_Z_ACCEL_LOW   8'h06
`define REG_FIFO_SETUP    8'h09

// ============================================================================
// Field positions
`define SETUP_MODE_HI     7
`define SETUP_MODE_LO     6
`define SETUP_LEVEL_HI    5
`define SETUP_LEVEL_LO    0

// ============================================================================
// Reset values and codes
`define FIFO_SETUP_RESET  8'h00
`define FIFO_MODE_OFF     2'h0
`define FIFO_MODE_CIRC    2'h1
`define FIFO_MODE_FILL    2'h2
`define FIFO_MODE_TRIG    2'h3
`define FIFO_DEPTH        6'h20
`define I2C_SLAVE_ADDR    7'h1d

`endif

//--- verilog/accel_sample_fifo_readout.v
/*
  Acceleration output readout and 32-sample FIFO, reached over an I2C slave
  port. Holds the axis data registers, FIFO status and FIFO setup.
  Assumes a 10 MHz clock, SCL/SDA arriving asynchronously, and sample strobes,
  sample data, trigger, sleep/active state and fast-read bit from logic on the
  same clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "accel_fifo_defines.vh"

module accel_sample_fifo_readout #(
  parameter [6:0] SLAVE_ADDR = `I2C_SLAVE_ADDR
) (
  input  wire        clock_i,
  input  wire        rstn_i,
  input  wire        scl_i,
  input  wire        sda_i,
  input  wire        sample_active_i,
  input  wire        sample_sleep_i,
  input  wire        sleep_i,
  input  wire        active_i,
  input  wire        fast_read_i,
  input  wire        trigger_i,
  input  wire [11:0] x_i,
  input  wire [11:0] y_i,
  input  wire [11:0] z_i,
  input  wire [7:0]  data_status_i,
  output reg         sda_o,
  output reg         sda_oen_o,
  output reg         fifo_irq_source_o,
  output reg         fifo_status_read_o,
  output reg  [2:0]  axis_high_read_o
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_AACK = 4'h2;
  localparam [3:0] ST_PTR  = 4'h3;
  localparam [3:0] ST_PACK = 4'h4;
  localparam [3:0] ST_WR   = 4'h5;
  localparam [3:0] ST_WACK = 4'h6;
  localparam [3:0] ST_RD   = 4'h7;
  localparam [3:0] ST_MACK = 4'h8;

  // ==========================================================================
  // Reset release and pin synchronisers
  reg rst_m_q;
  reg rst_n_q;
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  reg scl_m_q, scl_s_q, scl_d_q;
  reg sda_m_q, sda_s_q, sda_d_q;
  always @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_d_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_d_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_d_q <= sda_s_q;
    end
  end

  wire scl_rise = scl_s_q & ~scl_d_q;
  wire scl_fall = ~scl_s_q & scl_d_q;
  wire bus_start = scl_s_q & scl_d_q & sda_d_q & ~sda_s_q;
  wire bus_stop  = scl_s_q & scl_d_q & ~sda_d_q & sda_s_q;

  // ==========================================================================
  // Register state
  reg  [7:0]  setup_q;
  reg  [7:0]  ptr_q;
  reg  [7:0]  last_rd_q;
  reg  [7:0]  frz_q;
  reg  [35:0] cur_q;
  reg  [5:0]  cnt_q;
  reg         ovf_q;
  reg         lvl_q;
  reg  [2:0]  fidx_q;
  reg  [35:0] mem [0:31];
  reg  [4:0]  wr_q;
  reg  [4:0]  rd_q;
  reg         trig_q;
  reg  [5:0]  post_q;
  reg         sleep_d_q;
  reg         active_d_q;

  wire [1:0] mode     = setup_q[`SETUP_MODE_HI:`SETUP_MODE_LO];
  wire [5:0] level    = setup_q[`SETUP_LEVEL_HI:`SETUP_LEVEL_LO];
  wire       fifo_en  = (mode != `FIFO_MODE_OFF);
  wire       fast     = fast_read_i;
  wire       fifo_last = fast ? (fidx_q == 3'h2) : (fidx_q == 3'h5);

  // Picks byte k (0..5: X high, X low, Y high, ...) of a packed sample.
  // Low bytes carry the four low bits left-justified.
  function [7:0] sample_byte;
    input [35:0] s;
    input [2:0]  k;
    reg   [11:0] axis;
    begin
      case (k[2:1])
        2'h0:    axis = s[35:24];
        2'h1:    axis = s[23:12];
        default: axis = s[11:0];
      endcase
      sample_byte = k[0] ? {axis[3:0], 4'h0} : axis[11:4];
    end
  endfunction

  function [7:0] next_ptr;
    input [7:0] p;
    input       en;
    input       fr;
    begin
      if (en && p == `REG_X_ACCEL_HIGH)
        next_ptr = p;
      else if (fr && (p == `REG_X_ACCEL_HIGH || p == `REG_Y_ACCEL_HIGH || p == `REG_Z_ACCEL_HIGH))
        next_ptr = p + 8'h02;
      else
        next_ptr = p + 8'h01;
    end
  endfunction

  // ==========================================================================
  // Read data selection
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    case (ptr_q)
      `REG_FIFO_STATUS:
        rd_byte = fifo_en ? {ovf_q, lvl_q, cnt_q} : data_status_i;
      `REG_X_ACCEL_HIGH:
        if (fifo_en)
          rd_byte = (cnt_q != 6'h00) ? sample_byte(mem[rd_q], fast ? {fidx_q[1:0], 1'b0} : fidx_q) : 8'h00;
        else
          rd_byte = sample_byte(cur_q, 3'h0);
      `REG_Y_ACCEL_HIGH:
        rd_byte = fifo_en ? 8'h00 : sample_byte(cur_q, 3'h2);
      `REG_Z_ACCEL_HIGH:
        rd_byte = fifo_en ? 8'h00 : sample_byte(cur_q, 3'h4);
      `REG_X_ACCEL_LOW, `REG_Y_ACCEL_LOW, `REG_Z_ACCEL_LOW:
        rd_byte = (!fifo_en && last_rd_q == ptr_q - 8'h01) ? frz_q : 8'h00;
      `REG_FIFO_SETUP:
        rd_byte = setup_q;
      default:
        rd_byte = 8'h00;
    endcase
  end

  // ==========================================================================
  // I2C slave
  reg [3:0] st_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg [7:0] tx_q;
  reg       rnw_q;
  reg       mack_q;

  wire fetch = scl_fall & ((st_q == ST_AACK & rnw_q) | (st_q == ST_MACK & ~mack_q));
  wire wr_en = scl_fall & (st_q == ST_WR) & (bit_q == 4'h8);

  always @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q      <= ST_IDLE;
      bit_q     <= 4'h0;
      sh_q      <= 8'h00;
      tx_q      <= 8'h00;
      rnw_q     <= 1'b0;
      mack_q    <= 1'b1;
      ptr_q     <= 8'h00;
      sda_o     <= 1'b0;
      sda_oen_o <= 1'b1;
    end else if (bus_start) begin
      st_q      <= ST_ADDR;
      bit_q     <= 4'h0;
      sda_oen_o <= 1'b1;
    end else if (bus_stop) begin
      st_q      <= ST_IDLE;
      sda_oen_o <= 1'b1;
    end else begin
      case (st_q)
        ST_ADDR, ST_PTR, ST_WR: begin
          if (scl_rise) begin
            sh_q  <= {sh_q[6:0], sda_s_q};
            bit_q <= bit_q + 4'h1;
          end
          if (scl_fall && bit_q == 4'h8) begin
            if (st_q == ST_ADDR) begin
              if (sh_q[7:1] == SLAVE_ADDR) begin
                st_q      <= ST_AACK;
                rnw_q     <= sh_q[0];
                sda_oen_o <= 1'b0;
              end else begin
                st_q <= ST_IDLE;
              end
            end else if (st_q == ST_PTR) begin
              ptr_q     <= sh_q;
              st_q      <= ST_PACK;
              sda_oen_o <= 1'b0;
            end else begin
              ptr_q     <= next_ptr(ptr_q, fifo_en, fast);
              st_q      <= ST_WACK;
              sda_oen_o <= 1'b0;
            end
          end
        end
        ST_AACK, ST_MACK: begin
          if (scl_rise)
            mack_q <= sda_s_q;
          if (fetch) begin
            tx_q      <= {rd_byte[6:0], 1'b0};
            sda_oen_o <= rd_byte[7];
            bit_q     <= 4'h1;
            ptr_q     <= next_ptr(ptr_q, fifo_en, fast);
            st_q      <= ST_RD;
          end else if (scl_fall) begin
            sda_oen_o <= 1'b1;
            bit_q     <= 4'h0;
            st_q      <= (st_q == ST_AACK) ? ST_PTR : ST_IDLE;
          end
        end
        ST_PACK, ST_WACK: begin
          if (scl_fall) begin
            sda_oen_o <= 1'b1;
            bit_q     <= 4'h0;
            st_q      <= ST_WR;
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (bit_q == 4'h8) begin
              sda_oen_o <= 1'b1;
              mack_q    <= 1'b1;
              st_q      <= ST_MACK;
            end else begin
              sda_oen_o <= tx_q[7];
              tx_q      <= {tx_q[6:0], 1'b0};
              bit_q     <= bit_q + 4'h1;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Sample intake and FIFO
  // Every flush source clears pointers, count, flags and trigger state at once,
  // so a stale pre-trigger history never leaks into a new capture.
  wire sample_stb = sleep_i ? sample_sleep_i : sample_active_i;
  wire flush = ~fifo_en | (sleep_i != sleep_d_q) | (active_i & ~active_d_q);
  wire [35:0] sample_in = {x_i, y_i, z_i};
  wire full = (cnt_q == `FIFO_DEPTH);
  wire [5:0] pre_lim  = (level == 6'h00 || level > `FIFO_DEPTH) ? `FIFO_DEPTH : level;
  wire [5:0] post_lim = `FIFO_DEPTH - pre_lim;
  wire stopped = trig_q & (post_q >= post_lim);
  wire pop = fetch & fifo_en & (ptr_q == `REG_X_ACCEL_HIGH) & fifo_last & (cnt_q != 6'h00);

  reg accept;
  reg discard;
  always @* begin
    accept  = 1'b0;
    discard = 1'b0;
    if (sample_stb && !flush) begin
      case (mode)
        `FIFO_MODE_CIRC: begin
          accept  = 1'b1;
          discard = full & ~pop;
        end
        `FIFO_MODE_FILL:
          accept = ~full | pop;
        `FIFO_MODE_TRIG:
          if (!trig_q) begin
            accept  = 1'b1;
            discard = (cnt_q >= pre_lim) & ~pop;
          end else begin
            accept = ~stopped & (~full | pop);
          end
        default: accept = 1'b0;
      endcase
    end
  end

  // A push in the same cycle as a pop leaves the count where it was.
  wire [5:0] cnt_d = flush ? 6'h00 : cnt_q + {5'h00, accept & ~discard} - {5'h00, pop};
  wire trig_d = ~flush & (trig_q | (mode == `FIFO_MODE_TRIG & trigger_i));
  wire ovf_d = flush ? 1'b0 :
               (mode == `FIFO_MODE_TRIG) ? (trig_q & post_q + {5'h00, accept} >= post_lim) :
               (cnt_d == `FIFO_DEPTH);
  wire lvl_d = flush ? 1'b0 :
               (mode == `FIFO_MODE_TRIG) ? trig_d :
               (level != 6'h00 && cnt_d >= level);
  wire cond_d = ovf_d | lvl_d;
  wire status_read = fetch & fifo_en & (ptr_q == `REG_FIFO_STATUS);
  wire irq_set = cond_d & (~(ovf_q | lvl_q) | accept);

  always @(posedge clock_i) begin
    if (accept)
      mem[wr_q] <= sample_in;
  end

  always @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      setup_q    <= `FIFO_SETUP_RESET;
      cnt_q      <= 6'h00;
      wr_q       <= 5'h00;
      rd_q       <= 5'h00;
      ovf_q      <= 1'b0;
      lvl_q      <= 1'b0;
      trig_q     <= 1'b0;
      post_q     <= 6'h00;
      fidx_q     <= 3'h0;
      sleep_d_q  <= 1'b0;
      active_d_q <= 1'b0;
      fifo_irq_source_o <= 1'b0;
    end else begin
      sleep_d_q  <= sleep_i;
      active_d_q <= active_i;
      if (wr_en && ptr_q == `REG_FIFO_SETUP)
        setup_q <= sh_q;
      cnt_q  <= cnt_d;
      ovf_q  <= ovf_d;
      lvl_q  <= lvl_d;
      trig_q <= trig_d;
      if (flush) begin
        wr_q   <= 5'h00;
        rd_q   <= 5'h00;
        post_q <= 6'h00;
      end else begin
        if (accept)
          wr_q <= wr_q + 5'h01;
        if (pop || (accept && discard))
          rd_q <= rd_q + 5'h01;
        if (accept && trig_q)
          post_q <= post_q + 6'h01;
      end
      if (bus_start)
        fidx_q <= 3'h0;
      else if (fetch && fifo_en && ptr_q == `REG_X_ACCEL_HIGH && cnt_q != 6'h00)
        fidx_q <= fifo_last ? 3'h0 : fidx_q + 3'h1;
      // Set wins over a clear in the same cycle.
      if (irq_set)
        fifo_irq_source_o <= 1'b1;
      else if (status_read)
        fifo_irq_source_o <= 1'b0;
    end
  end

  // ==========================================================================
  // Direct data registers and low-byte freeze
  always @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cur_q              <= 36'h000000000;
      frz_q              <= 8'h00;
      last_rd_q          <= 8'hff;
      fifo_status_read_o <= 1'b0;
      axis_high_read_o   <= 3'h0;
    end else begin
      if (sample_stb)
        cur_q <= sample_in;
      fifo_status_read_o <= status_read;
      axis_high_read_o   <= 3'h0;
      if (fetch) begin
        last_rd_q <= ptr_q;
        if (!fifo_en) begin
          case (ptr_q)
            `REG_X_ACCEL_HIGH: begin
              frz_q               <= sample_byte(cur_q, 3'h1);
              axis_high_read_o[0] <= 1'b1;
            end
            `REG_Y_ACCEL_HIGH: begin
              frz_q               <= sample_byte(cur_q, 3'h3);
              axis_high_read_o[1] <= 1'b1;
            end
            `REG_Z_ACCEL_HIGH: begin
              frz_q               <= sample_byte(cur_q, 3'h5);
              axis_high_read_o[2] <= 1'b1;
            end
            default: frz_q <= frz_q;
          endcase
        end
      end
    end
  end

endmodule

`default_nettype wire
